/* File: hdl/smem_ctrl.sv */
// Static memory controller core with slow clock and page mode reads.
// Notes on behaviour
// - The wait input is seen only through a two flip-flop synchroniser.
// - With slow clock indicated, fixed waveforms replace programmed ones on all selects.
// - Slow reads: strobe setup 1, pulse 1, select setup 0, pulse 2, cycle 2.
// - Slow writes: strobe setup 1, pulse 1, select setup 0, pulse 3, cycle 3.
// - A transfer running when slow mode ends finishes with slow lengths.
// - Page reads happen only with page mode on; page size is 4 to 32 bytes.
// - Pages are aligned; upper address bits form the page, lower bits the offset.
// - In-page address drops bit 0 for 16-bit and bits 1:0 for 32-bit memory.
// - In page mode, outside slow clock, read strobe and select stay low together for every read.
// - First page access uses select read pulse, later ones read strobe pulse.
// - Page reads ignore read control choice, setups and total read cycle.
// - Page pulse values are applied as programmed without any coherency check.
// - Byte access type still applies during page mode reads.
// - Same select and page as before means short access, sequential or not.
// - A different page or a different select starts a long first access.
// - Any other access in between drops the select and breaks the page.
// - Each select has setup, pulse, cycle and mode words at stride 0x10.
// - A mode register write inserts one reload wait state before the next access.
// - Wait mode 00 off, 01 reserved, 10 frozen, 11 ready.
// - The synchronised wait input counts only during the controlling pulse.
//
// Chosen here: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none

module smem_ctrl (
  // Clock and reset.
  input  wire logic                        clk,
  input  wire logic                        srst,
  // Wishbone register slave.
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [7:0]                  wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [31:0]                 wb_dat_i,
  output var  logic [31:0]                 wb_dat_o,
  output var  logic                        wb_ack_o,
  // Access requests from the system side.
  input  wire logic                        acc_req,
  input  wire logic                        acc_we,
  input  wire logic [smem_pkg::CS_W-1:0]   acc_cs,
  input  wire logic [smem_pkg::ADDR_W-1:0] acc_addr,
  input  wire logic [3:0]                  acc_be,
  input  wire logic                        other_access,
  output var  logic                        acc_done,
  // Power management indication.
  input  wire logic                        slow_clk_mode,
  // External memory pins.
  input  wire logic                        ext_wait_n,
  output var  logic [smem_pkg::NUM_CS-1:0] chip_select_n,
  output var  logic                        read_strobe_n,
  output var  logic                        write_strobe_n,
  output var  logic [3:0]                  byte_lane_n,
  output var  logic [smem_pkg::ADDR_W-1:0] mem_addr
);
  import smem_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_RELOAD, ST_RUN} smem_state_e;

  function automatic logic [LEN_W-1:0] setup_len(input logic [7:0] f);
    setup_len = {2'h0, f[5], 2'h0, f[4:0]};
  endfunction

  function automatic logic [LEN_W-1:0] pulse_len(input logic [7:0] f);
    pulse_len = {1'h0, f[6], 2'h0, f[5:0]};
  endfunction

  function automatic logic [LEN_W-1:0] cycle_len(input logic [8:0] f);
    cycle_len = {f[8:7], 1'h0, f[6:0]};
  endfunction

  function automatic logic [ADDR_W-1:0] page_base(input logic [ADDR_W-1:0] a,
                                                  input logic [1:0] ps);
    logic [ADDR_W-1:0] m;
    m = ~((26'h000_0001 << (PAGE_MIN_SHIFT + ps)) - 26'h000_0001);
    page_base = a & m;
  endfunction

  function automatic logic [31:0] merge_sel(input logic [31:0] old_w,
                                            input logic [31:0] new_w,
                                            input logic [3:0] sel);
    for (int i = 0; i < 4; i++)
    begin
      merge_sel[i*8 +: 8] = sel[i] ? new_w[i*8 +: 8] : old_w[i*8 +: 8];
    end
  endfunction

  logic [31:0] setup_ff [NUM_CS];
  logic [31:0] pulse_ff [NUM_CS];
  logic [31:0] cycle_ff [NUM_CS];
  logic [31:0] mode_ff [NUM_CS];

  smem_state_e       state_ff;
  logic [LEN_W-1:0]  cnt_ff;
  logic [LEN_W-1:0]  p_ss_ff, p_sp_ff, p_css_ff, p_csp_ff, p_last_ff;
  logic              p_we_ff, p_ctl_stb_ff, p_bat_ff, p_page_ff, p_slow_ff;
  logic [1:0]        p_wait_ff;
  logic [CS_W-1:0]   p_cs_ff;
  logic [3:0]        p_be_ff;
  logic              wait_s1_ff, wait_s2_ff, slow_ff, reload_pend_ff;
  logic              pg_valid_ff;
  logic [CS_W-1:0]   pg_cs_ff;
  logic [ADDR_W-1:0] pg_addr_ff;

  // Register bus decode.
  logic [CS_W-1:0] wb_cs;
  logic [7:0]      wb_loc;
  logic            wb_req, wb_fire, mode_wr_evt;
  logic [31:0]     rd_word;

  assign wb_cs = wb_adr_i[6:4];
  assign wb_loc = {4'h0, wb_adr_i[3:0]};
  assign wb_req = wb_cyc_i && wb_stb_i;
  assign wb_fire = wb_req && wb_ack_o;
  assign mode_wr_evt = wb_fire && wb_we_i && (wb_adr_i < REG_SPAN) && (wb_loc == OFS_MODE);

  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (wb_adr_i == OFS_STATUS)
    begin
      rd_word[STAT_BUSY_BIT] = (state_ff != ST_IDLE);
      rd_word[STAT_SLOW_BIT] = slow_ff;
      rd_word[STAT_PAGE_BIT] = pg_valid_ff;
    end
    else if (wb_adr_i >= REG_SPAN)
      rd_word = 32'h0000_0000;
    else if (wb_loc == OFS_SETUP)
      rd_word = setup_ff[wb_cs];
    else if (wb_loc == OFS_PULSE)
      rd_word = pulse_ff[wb_cs];
    else if (wb_loc == OFS_CYCLE)
      rd_word = cycle_ff[wb_cs];
    else if (wb_loc == OFS_MODE)
      rd_word = mode_ff[wb_cs];
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wb_req && !wb_ack_o;
      if (wb_req && !wb_ack_o)
        wb_dat_o <= rd_word;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      for (int i = 0; i < NUM_CS; i++)
      begin
        setup_ff[i] <= RST_SETUP;
        pulse_ff[i] <= RST_PULSE;
        cycle_ff[i] <= RST_CYCLE;
        mode_ff[i] <= RST_MODE;
      end
    end
    else if (wb_fire && wb_we_i && (wb_adr_i < REG_SPAN))
    begin
      if (wb_loc == OFS_SETUP)
        setup_ff[wb_cs] <= merge_sel(setup_ff[wb_cs], wb_dat_i, wb_sel_i);
      else if (wb_loc == OFS_PULSE)
        pulse_ff[wb_cs] <= merge_sel(pulse_ff[wb_cs], wb_dat_i, wb_sel_i);
      else if (wb_loc == OFS_CYCLE)
        cycle_ff[wb_cs] <= merge_sel(cycle_ff[wb_cs], wb_dat_i, wb_sel_i);
      else if (wb_loc == OFS_MODE)
        mode_ff[wb_cs] <= merge_sel(mode_ff[wb_cs], wb_dat_i, wb_sel_i);
    end
  end

  // Wait pin synchroniser and slow clock tracking.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wait_s1_ff <= 1'b1;
      wait_s2_ff <= 1'b1;
      slow_ff <= 1'b0;
    end
    else
    begin
      wait_s1_ff <= ext_wait_n;
      wait_s2_ff <= wait_s1_ff;
      slow_ff <= slow_clk_mode;
    end
  end

  // Configuration reload is owed after a mode write or a slow mode change.
  always_ff @(posedge clk)
  begin
    if (srst)
      reload_pend_ff <= 1'b0;
    else if (mode_wr_evt || (slow_clk_mode != slow_ff))
      reload_pend_ff <= 1'b1;
    else if (state_ff == ST_RELOAD)
      reload_pend_ff <= 1'b0;
  end

  // Parameters of the requested access.
  logic [31:0]      rq_mode, rq_setup, rq_pulse, rq_cycle;
  logic             rq_page, pg_hit, need_break;
  logic [LEN_W-1:0] nxt_p_ss, nxt_p_sp, nxt_p_css, nxt_p_csp, nxt_p_cyc;
  logic [1:0]       nxt_p_wait;
  logic             nxt_p_ctl_stb;
  logic [ADDR_W-1:0] nxt_addr;

  assign rq_mode = mode_ff[acc_cs];
  assign rq_setup = setup_ff[acc_cs];
  assign rq_pulse = pulse_ff[acc_cs];
  assign rq_cycle = cycle_ff[acc_cs];
  assign rq_page = rq_mode[PAGE_MODE_EN_BIT] && !acc_we;
  assign pg_hit = rq_page && pg_valid_ff && (acc_cs == pg_cs_ff) &&
                  (page_base(acc_addr, rq_mode[PS_LSB +: 2]) ==
                   page_base(pg_addr_ff, rq_mode[PS_LSB +: 2]));
  assign need_break = pg_valid_ff && (other_access || (acc_req && !pg_hit));

  always_comb
  begin
    nxt_p_ctl_stb = acc_we ? rq_mode[WRITE_MODE_BIT] : rq_mode[READ_MODE_BIT];
    nxt_p_wait = rq_mode[WAIT_MODE_LSB +: 2];
    nxt_addr = acc_addr;
    if (slow_ff)
    begin
      nxt_p_wait = WAIT_OFF;
      nxt_p_ss = acc_we ? SLOW_WR_SETUP : SLOW_RD_SETUP;
      nxt_p_sp = acc_we ? SLOW_WR_PULSE : SLOW_RD_PULSE;
      nxt_p_css = acc_we ? SLOW_CS_WR_SETUP : SLOW_CS_RD_SETUP;
      nxt_p_csp = acc_we ? SLOW_CS_WR_PULSE : SLOW_CS_RD_PULSE;
      nxt_p_cyc = acc_we ? SLOW_WR_CYCLE : SLOW_RD_CYCLE;
    end
    else if (rq_page)
    begin
      nxt_p_wait = WAIT_OFF;
      nxt_p_ss = '0;
      nxt_p_css = '0;
      nxt_p_sp = pg_hit ? pulse_len(rq_pulse[RD_STB_LSB +: 8])
                        : pulse_len(rq_pulse[CS_RD_LSB +: 8]);
      nxt_p_csp = nxt_p_sp;
      nxt_p_cyc = nxt_p_sp;
      if (rq_mode[DBW_LSB +: 2] == DBW_16)
        nxt_addr[0] = 1'b0;
      else if (rq_mode[DBW_LSB +: 2] == DBW_32)
        nxt_addr[1:0] = 2'h0;
    end
    else
    begin
      nxt_p_ss = setup_len(rq_setup[(acc_we ? WR_STB_LSB : RD_STB_LSB) +: 8]);
      nxt_p_sp = pulse_len(rq_pulse[(acc_we ? WR_STB_LSB : RD_STB_LSB) +: 8]);
      nxt_p_css = setup_len(rq_setup[(acc_we ? CS_WR_LSB : CS_RD_LSB) +: 8]);
      nxt_p_csp = pulse_len(rq_pulse[(acc_we ? CS_WR_LSB : CS_RD_LSB) +: 8]);
      nxt_p_cyc = cycle_len(rq_cycle[(acc_we ? WR_CYC_LSB : RD_CYC_LSB) +: 9]);
    end
  end

  // Waveform position of the running access.
  logic [LEN_W:0] ctl_s, ctl_e, cs_e, stb_e, cnt_x;
  logic           ctl_pulse, hold, cs_low, stb_low, go_run, req_ok;

  assign cnt_x = {1'b0, cnt_ff};
  assign ctl_s = {1'b0, p_ctl_stb_ff ? p_ss_ff : p_css_ff};
  assign ctl_e = ctl_s + {1'b0, p_ctl_stb_ff ? p_sp_ff : p_csp_ff};
  assign cs_e = {1'b0, p_css_ff} + {1'b0, p_csp_ff};
  assign stb_e = {1'b0, p_ss_ff} + {1'b0, p_sp_ff};
  assign cs_low = (cnt_x >= {1'b0, p_css_ff}) && (cnt_x < cs_e);
  assign stb_low = (cnt_x >= {1'b0, p_ss_ff}) && (cnt_x < stb_e);
  assign ctl_pulse = (state_ff == ST_RUN) && (cnt_x >= ctl_s) && (cnt_x < ctl_e);
  assign hold = ctl_pulse && !wait_s2_ff &&
                ((p_wait_ff == WAIT_FROZEN) ||
                 ((p_wait_ff == WAIT_READY) && (cnt_x == ctl_e - 11'h001)));
  assign req_ok = acc_req && !acc_done && !need_break;
  assign go_run = (state_ff == ST_RELOAD) ||
                  ((state_ff == ST_IDLE) && req_ok && !reload_pend_ff);

  always_ff @(posedge clk)
  begin
    if (srst)
      state_ff <= ST_IDLE;
    else
      case (state_ff)
        ST_IDLE:
          if (req_ok && reload_pend_ff)
            state_ff <= ST_RELOAD;
          else if (req_ok)
            state_ff <= ST_RUN;
        ST_RELOAD:
          state_ff <= ST_RUN;
        ST_RUN:
          if (!hold && (cnt_ff == p_last_ff))
            state_ff <= ST_IDLE;
        default:
          state_ff <= ST_IDLE;
      endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      cnt_ff <= '0;
    else if (state_ff != ST_RUN)
      cnt_ff <= '0;
    else if (!hold)
      cnt_ff <= cnt_ff + 10'h001;
  end

  // Access parameters are latched at start and kept until the end.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      {p_ss_ff, p_sp_ff, p_css_ff, p_csp_ff, p_last_ff} <= '0;
      {p_we_ff, p_ctl_stb_ff, p_bat_ff, p_page_ff, p_slow_ff} <= '0;
      p_wait_ff <= WAIT_OFF;
      p_cs_ff <= '0;
      p_be_ff <= '0;
      mem_addr <= '0;
    end
    else if (go_run)
    begin
      p_ss_ff <= nxt_p_ss;
      p_sp_ff <= nxt_p_sp;
      p_css_ff <= nxt_p_css;
      p_csp_ff <= nxt_p_csp;
      p_last_ff <= (nxt_p_cyc == '0) ? '0 : nxt_p_cyc - 10'h001;
      p_we_ff <= acc_we;
      p_ctl_stb_ff <= nxt_p_ctl_stb;
      p_bat_ff <= rq_mode[BAT_BIT];
      p_page_ff <= rq_page && !slow_ff;
      p_slow_ff <= slow_ff;
      p_wait_ff <= nxt_p_wait;
      p_cs_ff <= acc_cs;
      p_be_ff <= acc_be;
      mem_addr <= nxt_addr;
    end
  end

  // Last page seen; the select stays low while the page is valid.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pg_valid_ff <= 1'b0;
      pg_cs_ff <= '0;
      pg_addr_ff <= '0;
    end
    else if ((state_ff == ST_RUN) && !hold && (cnt_ff == p_last_ff))
    begin
      pg_valid_ff <= p_page_ff;
      pg_cs_ff <= p_cs_ff;
      pg_addr_ff <= mem_addr;
    end
    else if ((state_ff == ST_IDLE) && need_break)
      pg_valid_ff <= 1'b0;
  end

  // Pin drive.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      chip_select_n <= '1;
      read_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
      byte_lane_n <= 4'hf;
      acc_done <= 1'b0;
    end
    else
    begin
      chip_select_n <= '1;
      read_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
      byte_lane_n <= 4'hf;
      acc_done <= (state_ff == ST_RUN) && !hold && (cnt_ff == p_last_ff);
      if (state_ff == ST_RUN)
      begin
        chip_select_n[p_cs_ff] <= !cs_low;
        if (!p_we_ff)
          read_strobe_n <= !stb_low;
        else if (!p_bat_ff)
          write_strobe_n <= !stb_low;
        if (!p_bat_ff && cs_low)
          byte_lane_n <= ~p_be_ff;
        else if (p_bat_ff && p_we_ff && stb_low)
          byte_lane_n <= ~p_be_ff;
      end
      else if (pg_valid_ff && !need_break)
        chip_select_n[pg_cs_ff] <= 1'b0;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_slow_rd_start;
    go_run && slow_ff && !acc_we && (state_ff != ST_RELOAD);
  endsequence

  sequence s_slow_wr_start;
    go_run && slow_ff && acc_we && (state_ff != ST_RELOAD);
  endsequence

  AST_FROZEN_HOLDS: assert property (((state_ff == ST_RUN) && (p_wait_ff == WAIT_FROZEN) &&
      ctl_pulse && !wait_s2_ff) |=> $stable(cnt_ff) && (state_ff == ST_RUN))
    else $error("frozen wait did not hold the access");
  AST_SLOW_RD: assert property (s_slow_rd_start |-> ##3 acc_done)
    else $error("slow read length wrong");
  AST_SLOW_WR: assert property (s_slow_wr_start |-> ##2 !acc_done ##1 !acc_done ##1 acc_done)
    else $error("slow write length wrong");
  AST_SLOW_KEEP: assert property (((state_ff == ST_RUN) && $past(state_ff == ST_RUN)) |->
      $stable(p_last_ff) && $stable(p_slow_ff))
    else $error("parameters changed during a transfer");
  AST_PAGE_LOW: assert property (((state_ff == ST_RUN) && p_page_ff) |=>
      !read_strobe_n && !chip_select_n[p_cs_ff])
    else $error("page read strobes not low together");
  AST_PAGE_HIT: assert property ((go_run && (state_ff == ST_IDLE) && pg_hit && !slow_ff) |=>
      (p_last_ff == $past(nxt_p_sp) - 10'h001) || (p_last_ff == '0))
    else $error("page hit did not use short access");
  AST_RELOAD: assert property ((mode_wr_evt && (state_ff == ST_IDLE) && !acc_req) |=>
      reload_pend_ff)
    else $error("mode write did not request reload");
  AST_WAIT_WINDOW: assert property (((state_ff == ST_RUN) && !ctl_pulse) |=>
      (cnt_ff != $past(cnt_ff)) || (state_ff != ST_RUN))
    else $error("wait acted outside the pulse");
  AST_VALID_CS: assert property ((pg_valid_ff && (state_ff == ST_IDLE) && !need_break) |=>
      !chip_select_n[pg_cs_ff])
    else $error("valid page without asserted select");
endmodule

`default_nettype wire

/* File: hdl/smem_pkg.sv */
// Constants shared by the static memory controller design.
package smem_pkg;
  localparam int unsigned NUM_CS = 8;
  localparam int unsigned CS_W = 3;
  localparam int unsigned ADDR_W = 26;
  localparam int unsigned LEN_W = 10;

  // Register offsets inside one chip select group, stride and span.
  localparam logic [7:0] OFS_SETUP = 8'h00;
  localparam logic [7:0] OFS_PULSE = 8'h04;
  localparam logic [7:0] OFS_CYCLE = 8'h08;
  localparam logic [7:0] OFS_MODE = 8'h0c;
  localparam logic [7:0] CS_STRIDE = 8'h10;
  localparam logic [7:0] REG_SPAN = 8'h80;
  localparam logic [7:0] OFS_STATUS = 8'h80;

  // Field positions (same layout in the setup and pulse registers).
  localparam int unsigned WR_STB_LSB = 0;
  localparam int unsigned CS_WR_LSB = 8;
  localparam int unsigned RD_STB_LSB = 16;
  localparam int unsigned CS_RD_LSB = 24;
  localparam int unsigned WR_CYC_LSB = 0;
  localparam int unsigned RD_CYC_LSB = 16;
  localparam int unsigned READ_MODE_BIT = 0;
  localparam int unsigned WRITE_MODE_BIT = 1;
  localparam int unsigned WAIT_MODE_LSB = 4;
  localparam int unsigned BAT_BIT = 8;
  localparam int unsigned DBW_LSB = 12;
  localparam int unsigned PAGE_MODE_EN_BIT = 24;
  localparam int unsigned PS_LSB = 28;
  localparam int unsigned PAGE_MIN_SHIFT = 2;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_SLOW_BIT = 1;
  localparam int unsigned STAT_PAGE_BIT = 2;

  localparam logic [1:0] DBW_16 = 2'h1;
  localparam logic [1:0] DBW_32 = 2'h2;

  typedef enum logic [1:0] {
    WAIT_OFF    = 2'h0,
    WAIT_RSVD   = 2'h1,
    WAIT_FROZEN = 2'h2,
    WAIT_READY  = 2'h3
  } smem_wait_e;

  // Reset values of the configuration registers.
  localparam logic [31:0] RST_SETUP = 32'h01010101;
  localparam logic [31:0] RST_PULSE = 32'h01010101;
  localparam logic [31:0] RST_CYCLE = 32'h00030003;
  localparam logic [31:0] RST_MODE = 32'h00000003;

  // Fixed waveform lengths, in clock cycles, while the slow clock is on.
  localparam logic [9:0] SLOW_RD_SETUP = 10'h001;
  localparam logic [9:0] SLOW_RD_PULSE = 10'h001;
  localparam logic [9:0] SLOW_CS_RD_SETUP = 10'h000;
  localparam logic [9:0] SLOW_CS_RD_PULSE = 10'h002;
  localparam logic [9:0] SLOW_RD_CYCLE = 10'h002;
  localparam logic [9:0] SLOW_WR_SETUP = 10'h001;
  localparam logic [9:0] SLOW_WR_PULSE = 10'h001;
  localparam logic [9:0] SLOW_CS_WR_SETUP = 10'h000;
  localparam logic [9:0] SLOW_CS_WR_PULSE = 10'h003;
  localparam logic [9:0] SLOW_WR_CYCLE = 10'h003;
endpackage

/* File: testbench/smem_ctrl_bench.sv */
// Self-checking bench for the static memory controller.
`timescale 1ns/1ps
`default_nettype none

module smem_ctrl_bench;
  import smem_pkg::*;

  logic              clk = 1'b0;
  logic              srst = 1'b1;
  logic              wb_cyc_i = 1'b0;
  logic              wb_stb_i = 1'b0;
  logic              wb_we_i = 1'b0;
  logic [7:0]        wb_adr_i = 8'h00;
  logic [31:0]       wb_dat_i = 32'h0;
  logic [31:0]       wb_dat_o;
  logic              wb_ack_o;
  logic              acc_req = 1'b0;
  logic              acc_we = 1'b0;
  logic [CS_W-1:0]   acc_cs = '0;
  logic [ADDR_W-1:0] acc_addr = '0;
  logic              other_access = 1'b0;
  logic              acc_done;
  logic              slow_clk_mode = 1'b0;
  logic              ext_wait_n;
  logic [NUM_CS-1:0] chip_select_n;
  logic              read_strobe_n;
  logic              write_strobe_n;
  logic [7:0]        wait_cycles = 8'h00;
  logic [ADDR_W-1:0] mem_addr;
  int                bad_count = 0;
  int                comparisons = 0;
  int                lat;
  int                cs_lo;
  int                st_lo;
  int                cs_hi;

  always #20 clk = ~clk;

  smem_ctrl dut_u (.clk(clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .acc_req(acc_req), .acc_we(acc_we),
    .acc_cs(acc_cs), .acc_addr(acc_addr), .acc_be(4'hf), .other_access(other_access),
    .acc_done(acc_done), .slow_clk_mode(slow_clk_mode), .ext_wait_n(ext_wait_n),
    .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .byte_lane_n(), .mem_addr(mem_addr));

  smem_mem_model mem_u (.clk(clk), .chip_select_n(chip_select_n),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .ext_wait_n(ext_wait_n), .wait_cycles(wait_cycles));

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Called right after a rising edge; returns right after one.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                    output logic [31:0] rd);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1)
      bad_count++;
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask

  // One transfer; counts select and strobe activity at each edge.
  task automatic acc(input logic we, input logic [2:0] cs, input logic [25:0] adr,
                     input logic drop);
    lat = 0;
    cs_lo = 0;
    st_lo = 0;
    cs_hi = 0;
    acc_req  <= 1'b1;
    acc_we   <= we;
    acc_cs   <= cs;
    acc_addr <= adr;
    do
    begin
      @(posedge clk);
      lat++;
      if (drop)
        slow_clk_mode <= 1'b0;
      cs_lo += int'(chip_select_n[cs] === 1'b0);
      cs_hi += int'(chip_select_n[cs] !== 1'b0);
      st_lo += int'((we ? write_strobe_n : read_strobe_n) === 1'b0);
    end
    while (acc_done !== 1'b1 && lat < 200);
    if (acc_done !== 1'b1)
      bad_count++;
    acc_req <= 1'b0;
    repeat (2)
    begin
      @(posedge clk);
      cs_lo += int'(chip_select_n[cs] === 1'b0);
      st_lo += int'((we ? write_strobe_n : read_strobe_n) === 1'b0);
    end
  endtask

  task automatic t_regs();
    logic [31:0] d;
    logic [31:0] rst[4];
    rst = '{RST_SETUP, RST_PULSE, RST_CYCLE, RST_MODE};
    for (int i = 0; i < 4; i++)
    begin
      wb(1'b0, 8'h70 + 8'(4 * i), 32'h0, d);
      chk("reset value", d, rst[i]);
    end
    wb(1'b1, 8'h14, 32'h05040302, d);
    wb(1'b0, 8'h14, 32'h0, d);
    chk("pulse cs1", d, 32'h05040302);
    wb(1'b0, 8'h04, 32'h0, d);
    chk("pulse cs0", d, RST_PULSE);
    wb(1'b1, 8'h90, 32'h12345678, d);
    wb(1'b0, 8'h90, 32'h0, d);
    chk("unmapped", d, 32'h0);
  endtask

  task automatic t_wait();
    logic [31:0] d;
    int          l0;
    // The model answers one cycle after the strobe and the design drives pins a cycle late.
    wb(1'b1, 8'h24, 32'h06050101, d);
    wb(1'b1, 8'h28, 32'h00080008, d);
    for (int m = 0; m < 4; m++)
    begin
      wb(1'b1, 8'h2c, 32'h3 | (32'(m) << 4), d);
      acc(1'b0, 3'h2, 26'h0, 1'b0);
      acc(1'b0, 3'h2, 26'h0, 1'b0);
      l0 = lat;
      wait_cycles <= 8'h05;
      acc(1'b0, 3'h2, 26'h0, 1'b0);
      wait_cycles <= 8'h00;
      chk("wait stretch", (m < 2) ? (lat == l0) : (m == 2) ? (lat - l0 == 5) : (lat > l0), 1);
    end
  endtask

  task automatic t_page();
    logic [31:0] d;
    int          h;
    int          m;
    wb(1'b1, 8'h30, 32'h05050101, d);
    wb(1'b1, 8'h34, 32'h06020101, d);
    wb(1'b1, 8'h3c, 32'h11000003, d);
    acc(1'b0, 3'h3, 26'h100, 1'b0);
    acc(1'b0, 3'h3, 26'h103, 1'b0);
    h = lat;
    chk("select held", cs_hi, 0);
    chk("page addr", {6'h00, mem_addr}, 32'h0000_0103);
    acc(1'b0, 3'h3, 26'h101, 1'b0);
    chk("nonseq hit", lat, h);
    acc(1'b0, 3'h3, 26'h108, 1'b0);
    chk("new page", (lat - h >= 4) && (lat - h <= 5), 1);
    other_access <= 1'b1;
    @(posedge clk);
    other_access <= 1'b0;
    acc(1'b0, 3'h3, 26'h109, 1'b0);
    chk("other access", lat - h >= 3, 1);
    acc(1'b0, 3'h4, 26'h109, 1'b0);
    acc(1'b0, 3'h3, 26'h10a, 1'b0);
    chk("select change", lat - h >= 3, 1);
    wb(1'b1, 8'h34, 32'h01060101, d);
    wb(1'b1, 8'h3c, 32'h11000003, d);
    acc(1'b0, 3'h3, 26'h200, 1'b0);
    acc(1'b0, 3'h3, 26'h300, 1'b0);
    m = lat;
    acc(1'b0, 3'h3, 26'h301, 1'b0);
    chk("short first", lat > m, 1);
  endtask

  task automatic t_slow();
    slow_clk_mode <= 1'b1;
    acc(1'b0, 3'h0, 26'h0, 1'b0);
    for (int c = 0; c < 3; c += 2)
    begin
      acc(1'b0, 3'(c), 26'h40, 1'b0);
      chk("slow rd select", cs_lo, 2);
      chk("slow rd strobe", st_lo, 1);
      acc(1'b1, 3'(c), 26'h40, 1'b0);
      chk("slow wr select", cs_lo, 3);
      chk("slow wr strobe", st_lo, 1);
    end
    acc(1'b0, 3'h0, 26'h44, 1'b1);
    chk("slow exit select", cs_lo, 2);
    chk("slow exit strobe", st_lo, 1);
  endtask

  initial
  begin
    #(40 * 20000);
    bad_count++;
    stop_test();
  end

  initial
  begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_wait();
    t_page();
    t_slow();
    stop_test();
  end
endmodule
`default_nettype wire

/* File: testbench/smem_mem_model.sv */
// Behavioural external memory that stretches accesses through its wait output.
`timescale 1ns/1ps
`default_nettype none

module smem_mem_model (
  // Clock.
  input  wire logic       clk,
  // Memory pins.
  input  wire logic [7:0] chip_select_n,
  input  wire logic       read_strobe_n,
  input  wire logic       write_strobe_n,
  output var  logic       ext_wait_n,
  // Wait length per strobe, zero for a prompt device.
  input  wire logic [7:0] wait_cycles
);
  logic       active;
  logic       strobe_ff = 1'b0;
  logic [7:0] left_ff   = 8'h00;

  assign active = ~&chip_select_n & ~(read_strobe_n & write_strobe_n);

  // Wait goes low one cycle after a selected strobe falls; the line idles high while no wait count is left.
  always_ff @(posedge clk)
  begin
    strobe_ff <= active;
    if (active & ~strobe_ff)
      left_ff <= wait_cycles;
    else if (left_ff != 8'h00)
      left_ff <= left_ff - 8'h01;
  end

  assign ext_wait_n = (left_ff == 8'h00);
endmodule
`default_nettype wire
